// *** e3_rx_monitor_params.svh ***
// Purpose: offsets, field positions, reset values and counts of the E3 receive monitor
// Assumes: 8-bit register space, byte-wide frame stream
// Notes: definitions only
`ifndef E3_RX_MONITOR_PARAMS_SVH
`define E3_RX_MONITOR_PARAMS_SVH

`define REG_PERSIST_CFG    8'h10
`define REG_ALARM_STATE    8'h11
`define REG_EVENT_FLAGS    8'h13
`define REG_EVENT_ENABLE   8'h16
`define REG_EVENT_CLEAR    8'h17

`define CFG_PERSIST_SEL    4
`define CFG_TMARK_SEL      3
`define CFG_RX_PLD_HI      7
`define CFG_RX_PLD_LO      5
`define STATE_FAIL_BIT     0
`define STATE_TMARK_BIT    1
`define EV_FERF_BIT        3
`define EV_BIP_BIT         2

`define MA_FERF_BIT        7
`define MA_FEBE_BIT        6
`define MA_PLD_HI          5
`define MA_PLD_LO          3
`define MA_TMARK_BIT       0

`define REG_RESET          8'h00
`define EV_USED_MASK       8'h0c
`define FERF_SHORT_RUN     3'h3
`define FERF_LONG_RUN      3'h5

`endif

// *** e3_rx_monitor_pkg.sv ***
// Purpose: types of the E3 receive monitor
// Assumes: nothing beyond the params header
// Notes: constants live in the header
package e3_rx_monitor_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [2:0] run_t;

	typedef enum logic
	{
		far_clear,
		far_failed
	} far_end_e;

endpackage : e3_rx_monitor_pkg

// *** e3_rx_ferf_bip8_monitor.sv ***
// Purpose: far-end failure persistence and BIP-8 check of the G.832 E3 receive path
// Assumes: an upstream delineator marks frame start, MA byte and EM byte on one clock
// Notes: register port is a plain strobe bus with read data one cycle late
// How it works
// - with persistence select 0, three consecutive frames with MA bit 7 set declare the failure.
// - with persistence select 1, five consecutive such frames are needed to declare it.
// - MA byte holds failure in bit 7, block error in bit 6, payload fields below, marker in bit 0.
// - declaring the failure sets event bit 3 of the event flag register.
// - declaring the failure sets bit 0 of the alarm state register.
// - the failure clears after 3 or 5 consecutive frames (same select) with MA bit 7 clear.
// - clearing the failure sets event bit 3 again, so entry and exit both interrupt.
// - clearing the failure returns bit 0 of the alarm state register to 0.
// - the XOR of every byte of a frame is compared with the EM byte of the next frame.
// - a match makes the local transmit framer send a block error bit of 0.
// - a mismatch makes the local transmit framer send a block error bit of 1.
// - a mismatch also sets event bit 2 of the event flag register.
`timescale 1ns/10ps
`include "e3_rx_monitor_params.svh"

module e3_rx_ferf_bip8_monitor
	import e3_rx_monitor_pkg::*;
#(
	parameter logic [2:0] EXPECTED_PAYLOAD = 3'h0
)
(
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_data_valid,
	input  wire logic       rx_frame_start,
	input  wire logic       rx_ma_byte,
	input  wire logic       rx_em_byte,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            febe_bit,
	output logic            febe_strobe,
	output logic            far_end_fail_state,
	output logic            irq
);

	function automatic logic hit(input byte_t addr, input byte_t target);
		hit = (addr == target);
	endfunction : hit

	far_end_e  far_state;
	run_t      fail_run;
	run_t      run_limit;
	byte_t     bip_acc;
	byte_t     bip_prev;
	logic      bip_prev_ok;
	logic      bip_acc_ok;
	byte_t     event_flags;
	byte_t     event_enable;
	logic      far_end_fail_persistence_select;
	logic      timing_marker_filter_select;
	logic [2:0] received_payload_kind;
	logic [2:0] expected_payload_kind;
	logic      tmark_state;
	logic      tmark_last;
	logic      ma_take;
	logic      em_take;
	logic      ma_ferf;
	logic      run_done;
	logic      far_change;
	logic      bip_mismatch;
	logic      flag_read;
	logic      flag_clear;
	byte_t     next_rdata;

	assign ma_take = rx_data_valid && rx_ma_byte;
	assign em_take = rx_data_valid && rx_em_byte && bip_prev_ok;
	assign ma_ferf = rx_data[`MA_FERF_BIT];
	assign expected_payload_kind = EXPECTED_PAYLOAD;
	// persistence depth; select may change at any time
	assign run_limit = far_end_fail_persistence_select ? `FERF_LONG_RUN : `FERF_SHORT_RUN;
	// >= so that a select change mid-run cannot wrap the counter
	assign run_done   = (fail_run >= run_limit - 3'h1);
	assign far_change = ma_take && (ma_ferf != (far_state == far_failed)) && run_done;
	assign bip_mismatch = (bip_prev != rx_data);
	assign flag_read    = reg_rd && hit(reg_addr, `REG_EVENT_FLAGS);
	assign flag_clear   = reg_wr && hit(reg_addr, `REG_EVENT_CLEAR);

	// far-end failure persistence
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			far_state <= far_clear;
			fail_run  <= 3'h0;
		end
		else if (ma_take)
		begin
			case (far_state)
				far_clear:
				begin
					if (!ma_ferf)
					begin
						fail_run <= 3'h0;
					end
					else if (run_done)
					begin
						far_state <= far_failed;
						fail_run  <= 3'h0;
					end
					else
					begin
						fail_run <= fail_run + 3'h1;
					end
				end
				far_failed:
				begin
					if (ma_ferf)
					begin
						fail_run <= 3'h0;
					end
					else if (run_done)
					begin
						far_state <= far_clear;
						fail_run  <= 3'h0;
					end
					else
					begin
						fail_run <= fail_run + 3'h1;
					end
				end
				default:
				begin
					far_state <= far_clear;
					fail_run  <= 3'h0;
				end
			endcase
		end
	end

	assign far_end_fail_state = (far_state == far_failed);

	// payload and timing marker capture from the MA byte
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			received_payload_kind <= 3'h0;
			tmark_state           <= 1'b0;
			tmark_last            <= 1'b0;
		end
		else if (ma_take)
		begin
			received_payload_kind <= rx_data[`MA_PLD_HI:`MA_PLD_LO];
			tmark_last            <= rx_data[`MA_TMARK_BIT];
			// filtered mode needs two frames in agreement before the marker moves
			if (!timing_marker_filter_select || (tmark_last == rx_data[`MA_TMARK_BIT]))
			begin
				tmark_state <= rx_data[`MA_TMARK_BIT];
			end
		end
	end

	// BIP-8 accumulation per frame
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			bip_acc     <= 8'h00;
			bip_prev    <= 8'h00;
			bip_prev_ok <= 1'b0;
			bip_acc_ok  <= 1'b0;
		end
		else if (rx_data_valid)
		begin
			if (rx_frame_start)
			begin
				bip_prev    <= bip_acc;
				bip_acc     <= rx_data;
				// no parity history until one whole frame has passed
				bip_prev_ok <= bip_acc_ok;
				bip_acc_ok  <= 1'b1;
			end
			else
			begin
				bip_acc <= bip_acc ^ rx_data;
			end
		end
	end

	// verdict to the local transmit framer
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			febe_bit    <= 1'b0;
			febe_strobe <= 1'b0;
		end
		else
		begin
			febe_strobe <= em_take;
			if (em_take)
			begin
				febe_bit <= bip_mismatch;
			end
		end
	end

	// sticky events; a new event beats a read or a clear in the same cycle
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			event_flags <= `REG_RESET;
		end
		else
		begin
			for (int i = 0; i < 8; i++)
			begin
				if ((i == `EV_FERF_BIT) && far_change)
				begin
					event_flags[i] <= 1'b1;
				end
				else if ((i == `EV_BIP_BIT) && em_take && bip_mismatch)
				begin
					event_flags[i] <= 1'b1;
				end
				else if (flag_read || (flag_clear && reg_wdata[i]))
				begin
					event_flags[i] <= 1'b0;
				end
			end
		end
	end

	// software-written controls
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			far_end_fail_persistence_select <= 1'b0;
			timing_marker_filter_select     <= 1'b0;
			event_enable                    <= `REG_RESET;
		end
		else if (reg_wr)
		begin
			if (hit(reg_addr, `REG_PERSIST_CFG))
			begin
				far_end_fail_persistence_select <= reg_wdata[`CFG_PERSIST_SEL];
				timing_marker_filter_select     <= reg_wdata[`CFG_TMARK_SEL];
			end
			if (hit(reg_addr, `REG_EVENT_ENABLE))
			begin
				event_enable <= reg_wdata & `EV_USED_MASK;
			end
		end
	end

	// read mux; unmapped and write-only addresses read zero
	always_comb
	begin
		next_rdata = 8'h00;
		case (reg_addr)
			`REG_PERSIST_CFG:
			begin
				next_rdata[`CFG_RX_PLD_HI:`CFG_RX_PLD_LO] = received_payload_kind;
				next_rdata[`CFG_PERSIST_SEL]              = far_end_fail_persistence_select;
				next_rdata[`CFG_TMARK_SEL]                = timing_marker_filter_select;
				next_rdata[2:0]                           = expected_payload_kind;
			end
			`REG_ALARM_STATE:
			begin
				next_rdata[`STATE_FAIL_BIT]  = far_end_fail_state;
				next_rdata[`STATE_TMARK_BIT] = tmark_state;
			end
			`REG_EVENT_FLAGS:
			begin
				next_rdata = event_flags;
			end
			`REG_EVENT_ENABLE:
			begin
				next_rdata = event_enable;
			end
			default:
			begin
				next_rdata = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst || !reg_rd)
		begin
			reg_rdata <= 8'h00;
		end
		else
		begin
			reg_rdata <= next_rdata;
		end
	end

	assign irq = |(event_flags & event_enable);

	// checking helpers: runs of MA failure bits seen, saturating
	run_t ones_run;
	run_t zeros_run;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			ones_run  <= 3'h0;
			zeros_run <= 3'h0;
		end
		else if (ma_take)
		begin
			ones_run  <= !ma_ferf ? 3'h0 : ((ones_run == 3'h7) ? ones_run : ones_run + 3'h1);
			zeros_run <= ma_ferf ? 3'h0 : ((zeros_run == 3'h7) ? zeros_run : zeros_run + 3'h1);
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	declare_short_a: assert property (
		$rose(far_end_fail_state) && $past(!far_end_fail_persistence_select)
			&& $stable(far_end_fail_persistence_select) |-> ones_run >= 3'h3)
		else $error("failure declared before three frames");
	declare_long_a: assert property (
		$rose(far_end_fail_state) && $past(far_end_fail_persistence_select)
			&& $stable(far_end_fail_persistence_select) |-> ones_run >= 3'h5)
		else $error("failure declared before five frames");
	clear_run_a: assert property (
		$fell(far_end_fail_state) && $past(!far_end_fail_persistence_select)
			&& $stable(far_end_fail_persistence_select) |-> zeros_run >= 3'h3)
		else $error("failure cleared before three clean frames");
	entry_event_a: assert property (
		$rose(far_end_fail_state) |-> event_flags[`EV_FERF_BIT])
		else $error("no event on failure entry");
	exit_event_a: assert property (
		$fell(far_end_fail_state) |-> event_flags[`EV_FERF_BIT])
		else $error("no event on failure exit");
	state_read_a: assert property (
		reg_rd && reg_addr == `REG_ALARM_STATE
			|=> reg_rdata[`STATE_FAIL_BIT] == $past(far_end_fail_state))
		else $error("alarm state read back wrong");
	febe_mismatch_a: assert property (
		em_take && bip_mismatch |=> febe_strobe && febe_bit ##0 event_flags[`EV_BIP_BIT])
		else $error("mismatch not reported");
	febe_match_a: assert property (
		em_take && !bip_mismatch |=> febe_strobe && !febe_bit)
		else $error("match reported as error");
	bip_event_a: assert property (
		event_flags[`EV_BIP_BIT] && !$past(event_flags[`EV_BIP_BIT]) |-> $past(em_take))
		else $error("parity event without EM check");
	read_clear_a: assert property (
		flag_read && !far_change && !(em_take && bip_mismatch) |=> event_flags == 8'h00)
		else $error("flag read did not clear");

	cov_declare_short: cover property (
		$rose(far_end_fail_state) && !far_end_fail_persistence_select);
	cov_declare_long: cover property (
		$rose(far_end_fail_state) && far_end_fail_persistence_select);
	cov_clear: cover property ($fell(far_end_fail_state));
	cov_bip_error: cover property (febe_strobe && febe_bit);

endmodule : e3_rx_ferf_bip8_monitor

// *** remote_e3_terminal.sv ***
// Purpose: remote E3 terminal seen through the line interface unit
// Assumes: frame is start, MA, EM and one payload byte
// Notes: bad flips EM bit 0 so the next check fails on purpose
`timescale 1ns/10ps
module remote_e3_terminal
(
	input  wire logic       clk_sys,
	output logic      [7:0] rx_data,
	output logic            rx_data_valid,
	output logic            rx_frame_start,
	output logic            rx_ma_byte,
	output logic            rx_em_byte
);
	logic [7:0] prev_bip = 8'h00;
	logic [7:0] run_bip  = 8'h00;
	initial
	begin
		rx_data = 8'h00;
		{rx_data_valid, rx_frame_start, rx_ma_byte, rx_em_byte} = 4'h0;
	end
	task automatic put(input logic [7:0] b, input logic [2:0] kind);
		@(posedge clk_sys);
		rx_data <= b;
		{rx_data_valid, rx_frame_start, rx_ma_byte, rx_em_byte} <= {1'b1, kind};
		run_bip = run_bip ^ b;
	endtask : put
	// idle line toggles, so a stale byte never looks settled
	task automatic idle(input int n);
		repeat (n)
		begin
			@(posedge clk_sys);
			rx_data <= ~rx_data;
			{rx_data_valid, rx_frame_start, rx_ma_byte, rx_em_byte} <= 4'h0;
		end
	endtask : idle
	task automatic send_frame(input logic ferf, input logic bad, input int gap);
		logic [7:0] em;
		em = prev_bip ^ {7'h00, bad};
		run_bip = 8'h00;
		put(8'h3c, 3'h4);
		put({ferf, 1'b0, 3'h5, 3'h0}, 3'h2);
		idle(gap);
		put(em, 3'h1);
		put(8'hc3, 3'h0);
		idle(1);
		prev_bip = run_bip;
		// hand back on a falling edge so callers compare settled outputs
		@(negedge clk_sys);
	endtask : send_frame
endmodule : remote_e3_terminal

// *** test_e3_rx_ferf_bip8_monitor.sv ***
// Purpose: self-checking bench of the E3 receive monitor
// Assumes: remote terminal model drives the frame stream
// Notes: rows cover the plain frame runs, the rest is hand-written
`timescale 1ns/10ps
`include "e3_rx_monitor_params.svh"
module test_e3_rx_ferf_bip8_monitor
	import e3_rx_monitor_pkg::*;
;
	typedef struct {logic ferf; logic bad; logic febe; logic fail;} row_s;
	logic       clk_sys = 1'b0;
	logic       srst = 1'b1;
	logic [7:0] rx_data;
	logic       rx_data_valid;
	logic       rx_frame_start;
	logic       rx_ma_byte;
	logic       rx_em_byte;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic       febe_bit;
	logic       febe_strobe;
	logic       far_end_fail_state;
	logic       irq;
	byte_t      strobes = 8'h00;
	int         bad_count = 0;
	int         compares = 0;
	row_s       rows[7] = '{'{0, 0, 0, 0}, '{1, 0, 0, 0}, '{1, 1, 1, 0}, '{1, 0, 0, 1},
		'{0, 0, 0, 1}, '{0, 0, 0, 1}, '{0, 0, 0, 0}};
	byte_t      addrs[6] = '{8'h10, 8'h11, 8'h13, 8'h16, 8'h17, 8'h20};

	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		if (febe_strobe === 1'b1)
			strobes <= strobes + 8'h01;

	e3_rx_ferf_bip8_monitor dut_u (.clk_sys, .srst, .rx_data, .rx_data_valid,
		.rx_frame_start, .rx_ma_byte, .rx_em_byte, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .febe_bit, .febe_strobe, .far_end_fail_state, .irq);
	remote_e3_terminal partner_u (.clk_sys, .rx_data, .rx_data_valid,
		.rx_frame_start, .rx_ma_byte, .rx_em_byte);

	task automatic chk_reg(input byte_t got, input byte_t exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic wr(input byte_t a, input byte_t d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input byte_t a, input byte_t e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk_reg(reg_rdata, e);
	endtask : rd
	task automatic end_of_test;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	initial
	begin
		#(40 * 5000);
		bad_count++;
		end_of_test();
	end

	initial
	begin
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		foreach (addrs[i])
			rd(addrs[i], 8'h00);
		chk_bit(irq, 1'b0);
		$display("reset test done");
		// odd rows leave a gap inside the frame, a slow far end
		for (int i = 0; i < 7; i++)
		begin
			partner_u.send_frame(rows[i].ferf, rows[i].bad, i % 2);
			chk_bit(febe_bit, rows[i].febe);
			chk_bit(far_end_fail_state, rows[i].fail);
		end
		$display("row test done");
		rd(`REG_EVENT_FLAGS, 8'h0c);
		rd(`REG_EVENT_FLAGS, 8'h00);
		rd(`REG_PERSIST_CFG, 8'ha0);
		wr(`REG_PERSIST_CFG, 8'hff);
		rd(`REG_PERSIST_CFG, 8'hb8);
		wr(`REG_PERSIST_CFG, 8'h10);
		wr(`REG_EVENT_ENABLE, 8'hff);
		rd(`REG_EVENT_ENABLE, 8'h0c);
		for (int i = 0; i < 5; i++)
		begin
			partner_u.send_frame(1'b1, 1'b0, 0);
			chk_bit(far_end_fail_state, i == 4);
		end
		chk_bit(irq, 1'b1);
		rd(`REG_ALARM_STATE, 8'h01);
		rd(`REG_EVENT_FLAGS, 8'h08);
		chk_bit(irq, 1'b0);
		$display("long run entry test done");
		wr(`REG_EVENT_ENABLE, 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			partner_u.send_frame(1'b0, i == 0, 2);
			chk_bit(far_end_fail_state, i != 4);
		end
		chk_bit(irq, 1'b0);
		rd(`REG_ALARM_STATE, 8'h00);
		wr(`REG_EVENT_CLEAR, 8'h0c);
		rd(`REG_EVENT_FLAGS, 8'h00);
		wr(8'h20, 8'hff);
		rd(8'h20, 8'h00);
		chk_reg(strobes, 8'h10);
		$display("long run exit test done");
		end_of_test();
	end
endmodule : test_e3_rx_ferf_bip8_monitor
